//--- hw/acmpc_pkg.sv
// Constants and types shared by the comparator control block.
package acmpc_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_CONTROL      = 8'h00;
    localparam logic [7:0] IDX_INPUT_SELECT = 8'h02;
    localparam logic [7:0] IDX_INT_ENABLE   = 8'h06;
    localparam logic [7:0] IDX_STATUS       = 8'h07;

    // Reset values.
    localparam logic [7:0] CONTROL_RESET      = 8'h00;
    localparam logic [7:0] INPUT_SELECT_RESET = 8'h00;
    localparam logic [7:0] INT_ENABLE_RESET   = 8'h00;

    // Writable bits of each register; the rest read as zero.
    localparam logic [7:0] CONTROL_WMASK      = 8'hFF;
    localparam logic [7:0] INPUT_SELECT_WMASK = 8'h8B;
    localparam logic [7:0] INT_ENABLE_WMASK   = 8'h01;

    // Field positions of comparator_control.
    localparam int CTL_ENABLE_BIT  = 0;
    localparam int CTL_HYST_LSB    = 1;
    localparam int CTL_LOWPWR_BIT  = 3;
    localparam int CTL_EDGE_LSB    = 4;
    localparam int CTL_OUTPUT_PAD_ENABLE_BIT   = 6;
    localparam int CTL_RUNSTBY_BIT = 7;

    // Field positions of input_select.
    localparam int SEL_NEG_LSB    = 0;
    localparam int SEL_POS_BIT    = 3;
    localparam int SEL_INVERT_BIT = 7;

    // Field positions of interrupt_enable and comparator_status.
    localparam int INTEN_FLAG_BIT  = 0;
    localparam int STAT_FLAG_BIT   = 0;
    localparam int STAT_STATE_BIT  = 4;

    // Edge select codes; code 2'h1 is reserved and selects no edge.
    localparam logic [1:0] EDGE_BOTH    = 2'h0;
    localparam logic [1:0] EDGE_FALLING = 2'h2;
    localparam logic [1:0] EDGE_RISING  = 2'h3;

    // Negative selector codes.
    localparam logic [1:0] NEG_PIN_0 = 2'h0;
    localparam logic [1:0] NEG_PIN_1 = 2'h1;
    localparam logic [1:0] NEG_VREF  = 2'h2;
    localparam logic [1:0] NEG_DAC   = 2'h3;

    // AHB-Lite constants.
    localparam int         HTRANS_ACTIVE_BIT = 1;
    localparam logic       HRESP_OKAY        = 1'b0;

    // Sleep state reported by the power manager.
    typedef enum logic [1:0] {
        SLEEP_ACTIVE    = 2'b00,
        SLEEP_IDLE      = 2'b01,
        SLEEP_STANDBY   = 2'b10,
        SLEEP_POWERDOWN = 2'b11
    } acmpc_sleep_e;

endpackage : acmpc_pkg

//--- hw/acmpc_top.sv
// Register slave, sleep gating, synchroniser and edge flag of the comparator control.
`timescale 1ns/1ps
`default_nettype none

module acmpc_top (
    // Clock, reset and clock enable
    input  wire logic                       CLK,
    input  wire logic                       RST,
    input  wire logic                       CE,
    // AHB-Lite slave
    input  wire logic                       HSEL,
    input  wire logic [31:0]                HADDR,
    input  wire logic [1:0]                 HTRANS,
    input  wire logic                       HWRITE,
    input  wire logic [2:0]                 HSIZE,
    input  wire logic [31:0]                HWDATA,
    input  wire logic                       HREADY,
    output logic      [31:0]                HRDATA,
    output logic                            HREADYOUT,
    output logic                            HRESP,
    // Power manager
    input  wire acmpc_pkg::acmpc_sleep_e    SLEEP_MODE,
    input  wire logic                       CLK_REQ_OTHER,
    // Analog comparator core
    input  wire logic                       COMP_RAW,
    output logic                            CMP_ENABLE,
    output logic                            POS_SEL,
    output logic      [1:0]                 NEG_SEL,
    output logic      [1:0]                 HYST_SEL,
    output logic                            LOW_POWER,
    // Pad, event system and interrupt controller
    output logic                            PAD_OUT,
    output logic                            PAD_OE,
    output logic                            EVENT_OUT,
    output logic                            IRQ
);
    import acmpc_pkg::*;

    logic [7:0] control;
    logic [7:0] input_select;
    logic [7:0] int_enable;
    logic       comparator_flag;
    logic       state_bit;
    logic [7:0] next_control;
    logic [7:0] next_input_select;
    logic [7:0] next_int_enable;
    logic       next_flag;
    logic       wr_pend;
    logic [7:0] wr_idx;
    logic       rd_pend;
    logic [7:0] rd_idx;
    logic       bus_take;
    logic       sync_1;
    logic       sync_2;
    logic       sync_3;
    logic       filtered;
    logic       result;
    logic       prev_result;
    logic       prev_valid;
    logic       in_standby;
    logic       in_powerdown;
    logic       func_on;
    logic       status_on;
    logic       rise;
    logic       fall;
    logic       edge_hit;
    logic [1:0] edge_select;

    function automatic logic [7:0] read_value(input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            IDX_CONTROL:      v = control;
            IDX_INPUT_SELECT: v = input_select;
            IDX_INT_ENABLE:   v = int_enable;
            IDX_STATUS: begin
                v[STAT_FLAG_BIT]  = comparator_flag;
                v[STAT_STATE_BIT] = state_bit;
            end
            default:          v = 8'h00;
        endcase
        return v;
    endfunction : read_value

    // Bus transfers are taken when the address phase sees HREADY high.
    assign bus_take = HSEL && HTRANS[HTRANS_ACTIVE_BIT] && HREADY;

    // Reads take one wait state so that a write just before is always visible.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wr_pend   <= 1'b0;
            wr_idx    <= 8'h00;
            rd_pend   <= 1'b0;
            rd_idx    <= 8'h00;
            HREADYOUT <= 1'b1;
            HRDATA    <= 32'h00000000;
            HRESP     <= HRESP_OKAY;
        end else if (CE) begin
            wr_pend <= bus_take && HWRITE && (HADDR[1:0] == 2'h0);
            wr_idx  <= HADDR[9:2];
            HRESP   <= HRESP_OKAY;
            if (rd_pend) begin
                rd_pend   <= 1'b0;
                HRDATA    <= {24'h000000, read_value(rd_idx)};
                HREADYOUT <= 1'b1;
            end else if (bus_take && !HWRITE) begin
                rd_pend   <= 1'b1;
                rd_idx    <= HADDR[9:2];
                HREADYOUT <= 1'b0;
            end
        end
    end

    // Sleep gating. Idle is treated as active, and nothing here looks at debug state.
    assign in_standby   = (SLEEP_MODE == SLEEP_STANDBY);
    assign in_powerdown = (SLEEP_MODE == SLEEP_POWERDOWN);
    assign func_on      = control[CTL_ENABLE_BIT] && !in_powerdown
                          && !(in_standby && !control[CTL_RUNSTBY_BIT]);
    assign status_on    = func_on && !(in_standby && !CLK_REQ_OTHER);

    // The core compares the voltages; a high raw level means positive is above negative.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sync_1   <= 1'b0;
            sync_2   <= 1'b0;
            sync_3   <= 1'b0;
            filtered <= 1'b0;
        end else if (CE) begin
            sync_1 <= COMP_RAW;
            sync_2 <= sync_1;
            sync_3 <= sync_2;
            if (sync_2 == sync_3) begin
                filtered <= sync_3;
            end
        end
    end

    assign result      = filtered ^ input_select[SEL_INVERT_BIT];
    assign edge_select = control[CTL_EDGE_LSB +: 2];
    assign rise        = prev_valid && result && !prev_result;
    assign fall        = prev_valid && !result && prev_result;

    always_comb begin
        case (edge_select)
            EDGE_BOTH:    edge_hit = rise || fall;
            EDGE_FALLING: edge_hit = fall;
            EDGE_RISING:  edge_hit = rise;
            default:      edge_hit = 1'b0;
        endcase
    end

    // The first sample after enabling only seeds the history; the enabled core's level, arriving later through the synchroniser, can still flag.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            prev_result <= 1'b0;
            prev_valid  <= 1'b0;
        end else if (CE) begin
            prev_result <= result;
            prev_valid  <= func_on;
        end
    end

    // Register updates; a hardware flag set beats a software clear in the same cycle.
    always_comb begin
        next_control      = control;
        next_input_select = input_select;
        next_int_enable   = int_enable;
        next_flag         = comparator_flag;
        if (wr_pend) begin
            case (wr_idx)
                IDX_CONTROL:      next_control      = HWDATA[7:0] & CONTROL_WMASK;
                IDX_INPUT_SELECT: next_input_select = HWDATA[7:0] & INPUT_SELECT_WMASK;
                IDX_INT_ENABLE:   next_int_enable   = HWDATA[7:0] & INT_ENABLE_WMASK;
                IDX_STATUS: begin
                    if (HWDATA[STAT_FLAG_BIT]) begin
                        next_flag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (status_on && edge_hit) begin
            next_flag = 1'b1;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            control         <= CONTROL_RESET;
            input_select    <= INPUT_SELECT_RESET;
            int_enable      <= INT_ENABLE_RESET;
            comparator_flag <= 1'b0;
            IRQ             <= 1'b0;
        end else if (CE) begin
            control         <= next_control;
            input_select    <= next_input_select;
            int_enable      <= next_int_enable;
            comparator_flag <= next_flag;
            IRQ             <= next_flag && next_int_enable[INTEN_FLAG_BIT];
        end
    end

    // Status state bit freezes while the peripheral clock is gone in standby with run-in-standby set, and clears while the function is off.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_bit <= 1'b0;
        end else if (CE) begin
            if (status_on) begin
                state_bit <= result;
            end else if (!func_on) begin
                state_bit <= 1'b0;
            end
        end
    end

    // Event and pad keep running in standby when run-in-standby is set.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            EVENT_OUT  <= 1'b0;
            PAD_OUT    <= 1'b0;
            PAD_OE     <= 1'b0;
            CMP_ENABLE <= 1'b0;
        end else if (CE) begin
            EVENT_OUT  <= func_on && result;
            PAD_OUT    <= func_on && result;
            PAD_OE     <= func_on && control[CTL_OUTPUT_PAD_ENABLE_BIT] && !in_powerdown;
            CMP_ENABLE <= func_on;
        end
    end

    // Select codes go to the core unchanged; the core decodes vref and DAC itself.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            POS_SEL   <= 1'b0;
            NEG_SEL   <= NEG_PIN_0;
            HYST_SEL  <= 2'h0;
            LOW_POWER <= 1'b0;
        end else if (CE) begin
            POS_SEL   <= next_input_select[SEL_POS_BIT];
            NEG_SEL   <= next_input_select[SEL_NEG_LSB +: 2];
            HYST_SEL  <= next_control[CTL_HYST_LSB +: 2];
            LOW_POWER <= next_control[CTL_LOWPWR_BIT];
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    irq_level_a: assert property (IRQ == (comparator_flag && int_enable[INTEN_FLAG_BIT]))
        else $error("Interrupt request does not follow flag and enable.");

    flag_set_a: assert property (CE && status_on && edge_hit |=> comparator_flag)
        else $error("Selected edge did not set the flag.");

    flag_keep_a: assert property (CE && comparator_flag &&
            !(wr_pend && wr_idx == IDX_STATUS && HWDATA[STAT_FLAG_BIT]) |=> comparator_flag)
        else $error("Flag cleared without a one written to it.");

    edge_mode_a: assert property (edge_select == EDGE_FALLING && rise |-> !edge_hit)
        else $error("Rising edge hit while falling edges are selected.");

    powerdown_off_a: assert property (CE && in_powerdown |=> !PAD_OE && !CMP_ENABLE)
        else $error("Function or pad still on in power-down.");

    standby_halt_a: assert property (CE && in_standby && !control[CTL_RUNSTBY_BIT]
            |=> !CMP_ENABLE && !EVENT_OUT)
        else $error("Function not halted in standby.");

    standby_freeze_a: assert property (CE && in_standby && !CLK_REQ_OTHER
            |=> $stable(state_bit) && !$rose(comparator_flag))
        else $error("Status changed in standby without clock.");

    event_follow_a: assert property (CE && func_on |=> EVENT_OUT == $past(result))
        else $error("Event output does not carry the result.");

    state_invert_a: assert property (CE && status_on
            |=> state_bit == ($past(filtered) ^ $past(input_select[SEL_INVERT_BIT])))
        else $error("State bit ignores the invert setting.");

    sync_delay_a: assert property ((CE && $stable(COMP_RAW))[*5] |-> filtered == COMP_RAW)
        else $error("Synchroniser did not settle within its depth.");

    read_wait_a: assert property (CE && bus_take && !HWRITE && !rd_pend
            |=> !HREADYOUT ##1 HREADYOUT)
        else $error("Read did not take exactly one wait state.");

    // The checks below watch the registered copies that leave the block. A stale copy
    // toward the core would go unnoticed by software, because reads return the register
    // and not the value that the core really sees.

    enable_copy_a: assert property (CE |=> CMP_ENABLE == $past(func_on))
        else $error("Comparator enable does not follow the gated enable.");

    pos_copy_a: assert property (CE |=> POS_SEL == input_select[SEL_POS_BIT])
        else $error("Positive select differs from its register field.");

    neg_copy_a: assert property (CE |=> NEG_SEL == input_select[SEL_NEG_LSB +: 2])
        else $error("Negative select differs from its register field.");

    hyst_copy_a: assert property (CE |=> HYST_SEL == control[CTL_HYST_LSB +: 2])
        else $error("Hysteresis select differs from its register field.");

    lowpwr_copy_a: assert property (CE |=> LOW_POWER == control[CTL_LOWPWR_BIT])
        else $error("Low-power control differs from its register field.");

    // Pad drive. The pad enable must drop whenever the function is off, or an
    // external load would see a stale level with no comparison behind it.

    pad_off_a: assert property (CE && !func_on |=> !PAD_OE && !PAD_OUT)
        else $error("Pad still driven while the function is off.");

    pad_follow_a: assert property (CE && func_on && control[CTL_OUTPUT_PAD_ENABLE_BIT]
            |=> PAD_OE && PAD_OUT == $past(result))
        else $error("Pad does not carry the result while enabled.");

    // Edge and flag behaviour. The first sample after enabling must never count as an
    // edge, since the history register still holds a value from before the start.

    first_sample_a: assert property (!prev_valid |-> !edge_hit)
        else $error("Edge reported without a valid previous sample.");

    reserved_edge_a: assert property (edge_select == 2'h1 |-> !edge_hit)
        else $error("Reserved edge code produced an edge.");

    flag_clear_a: assert property (CE && wr_pend && wr_idx == IDX_STATUS
            && HWDATA[STAT_FLAG_BIT] && !(status_on && edge_hit) |=> !comparator_flag)
        else $error("Writing one did not clear the flag.");

    state_off_a: assert property (CE && !func_on |=> !state_bit)
        else $error("State bit set while the function is off.");

    int_mask_a: assert property ((int_enable & ~INT_ENABLE_WMASK) == 8'h00)
        else $error("Interrupt enable holds bits that cannot be written.");

    sel_mask_a: assert property ((input_select & ~INPUT_SELECT_WMASK) == 8'h00)
        else $error("Input select holds bits that cannot be written.");

endmodule : acmpc_top

`default_nettype wire

//--- tb/acmpc_core_model.sv
// Behavioural comparator core that routes the selected inputs and compares them.
`timescale 1ns/1ps
`default_nettype none

module acmpc_core_model (
    // Selects from the control block
    input  wire logic       cmp_enable,
    input  wire logic       pos_sel,
    input  wire logic [1:0] neg_sel,
    // Input levels in arbitrary units
    input  wire logic [7:0] pin_p0,
    input  wire logic [7:0] pin_p1,
    input  wire logic [7:0] pin_n0,
    input  wire logic [7:0] pin_n1,
    input  wire logic [7:0] vref,
    input  wire logic [7:0] dac,
    // Raw result
    output logic            comp_raw
);
    logic [7:0] v_pos;
    logic [7:0] v_neg;

    always_comb begin
        v_pos = pos_sel ? pin_p1 : pin_p0;
        case (neg_sel)
            2'h0: v_neg = pin_n0;
            2'h1: v_neg = pin_n1;
            2'h2: v_neg = vref;
            default: v_neg = dac;
        endcase
        // A core that is off has no valid output, so it shows 0 rather than a held level.
        comp_raw = cmp_enable && (v_pos > v_neg);
    end
endmodule : acmpc_core_model
`default_nettype wire

//--- tb/acmpc_top_tb.sv
// Self-checking bench of the comparator control block.
`timescale 1ns/1ps
`default_nettype none

module acmpc_top_tb;
    import acmpc_pkg::*;
    logic         clk, rst, hsel, hwrite, clk_req, comp_raw, hreadyout, hresp, ce;
    logic         cmp_en, pos_sel, low_power, pad_out, pad_oe, event_out, irq;
    logic [1:0]   htrans, neg_sel, hyst_sel;
    logic [31:0]  haddr, hwdata, hrdata;
    logic [7:0]   p0, p1, n0, n1, vref, dac;
    acmpc_sleep_e sleep;
    int           n_mismatch, checks_done, cycles;
    // Bit 8 is the expected result, bits 7:0 the input select value.
    logic [8:0]   rows [9] = '{9'h100, 9'h001, 9'h102, 9'h103, 9'h008,
                               9'h00A, 9'h10B, 9'h181, 9'h080};

    acmpc_top i_acmpc_top (.CLK(clk), .RST(rst), .CE(ce), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .SLEEP_MODE(sleep),
        .CLK_REQ_OTHER(clk_req), .COMP_RAW(comp_raw), .CMP_ENABLE(cmp_en), .POS_SEL(pos_sel),
        .NEG_SEL(neg_sel), .HYST_SEL(hyst_sel), .LOW_POWER(low_power), .PAD_OUT(pad_out),
        .PAD_OE(pad_oe), .EVENT_OUT(event_out), .IRQ(irq));

    acmpc_core_model i_acmpc_core_model (.cmp_enable(cmp_en), .pos_sel(pos_sel),
        .neg_sel(neg_sel), .pin_p0(p0), .pin_p1(p1), .pin_n0(n0), .pin_n1(n1),
        .vref(vref), .dac(dac), .comp_raw(comp_raw));

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic chb(input string nm, input logic e, input logic g);
        chk(nm, {7'h0, e}, {7'h0, g});
    endtask : chb

    task automatic bus(input logic w, input logic [7:0] idx, d, output logic [7:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'h0};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata[7:0];
    endtask : bus

    task automatic wr(input logic [7:0] idx, d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
        // The write lands at the last edge of the task; let it settle before any compare.
        @(posedge clk);
    endtask : wr

    task automatic rdc(input string nm, input logic [7:0] idx, m, e);
        logic [7:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk(nm, e, q & m);
    endtask : rdc

    task automatic settle;
        repeat (8) @(posedge clk);
    endtask : settle

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // The whole sequence needs a few hundred cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    initial begin
        {rst, hsel, hwrite, clk_req, htrans, haddr, hwdata} = '0;
        rst = 1'b1;
        ce = 1'b1;
        sleep = SLEEP_ACTIVE;
        {p0, p1, n0, n1, vref, dac} = {8'h10, 8'h32, 8'h50, 8'h78, 8'h3C, 8'h28};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chb("hreadyout", 1'b1, hreadyout);
        chb("irq", 1'b0, irq);
        chb("pad_oe", 1'b0, pad_oe);
        rdc("control", IDX_CONTROL, 8'hFF, CONTROL_RESET);
        rdc("input_select", IDX_INPUT_SELECT, 8'hFF, INPUT_SELECT_RESET);
        rdc("int_enable", IDX_INT_ENABLE, 8'hFF, INT_ENABLE_RESET);
        rdc("status", IDX_STATUS, 8'hFF, 8'h00);
        $display("test reset done");
        wr(IDX_INPUT_SELECT, 8'hFF);
        rdc("input_select", IDX_INPUT_SELECT, 8'hFF, 8'h8B);
        wr(IDX_INT_ENABLE, 8'hFF);
        rdc("int_enable", IDX_INT_ENABLE, 8'hFF, 8'h01);
        wr(8'h01, 8'hFF);
        rdc("unmapped", 8'h01, 8'hFF, 8'h00);
        for (int i = 0; i < 4; i++) begin
            logic [1:0] h;
            h = i[1:0];
            wr(IDX_CONTROL, {4'h0, h[0], h, 1'b0});
            chk("hyst_sel", {6'h0, hyst_sel}, {6'h0, h});
            chb("low_power", h[0], low_power);
            rdc("control", IDX_CONTROL, 8'hFF, {4'h0, h[0], h, 1'b0});
        end
        $display("test registers done");
        p0 <= 8'h64;
        wr(IDX_CONTROL, 8'h41);
        settle();
        for (int r = 0; r < 9; r++) begin
            wr(IDX_INPUT_SELECT, rows[r][7:0]);
            settle();
            chk("neg_sel", {6'h0, neg_sel}, {6'h0, rows[r][1:0]});
            chb("pos_sel", rows[r][3], pos_sel);
            chb("event", rows[r][8], event_out);
            chk("pad", {6'h0, pad_oe, pad_out}, {6'h0, 1'b1, rows[r][8]});
            rdc("state", IDX_STATUS, 8'h10, {3'h0, rows[r][8], 4'h0});
        end
        $display("test inputs done");
        wr(IDX_INPUT_SELECT, 8'h00);
        p0 <= 8'h10;
        sleep <= SLEEP_IDLE;
        for (int c = 0; c < 4; c++) begin
            logic [1:0] e;
            e = c[1:0];
            wr(IDX_CONTROL, {2'h0, e, 4'h1});
            settle();
            wr(IDX_STATUS, 8'h01);
            p0 <= 8'h64;
            settle();
            rdc("flag_rise", IDX_STATUS, 8'h01, {7'h0, e == EDGE_BOTH || e == EDGE_RISING});
            chb("irq_rise", e == EDGE_BOTH || e == EDGE_RISING, irq);
            wr(IDX_STATUS, 8'h01);
            p0 <= 8'h10;
            settle();
            rdc("flag_fall", IDX_STATUS, 8'h01, {7'h0, e == EDGE_BOTH || e == EDGE_FALLING});
        end
        $display("test edges done");
        wr(IDX_CONTROL, 8'h01);
        p0 <= 8'h64;
        settle();
        wr(IDX_STATUS, 8'h00);
        rdc("flag_w0", IDX_STATUS, 8'h01, 8'h01);
        chb("irq_held", 1'b1, irq);
        wr(IDX_INT_ENABLE, 8'h00);
        chb("irq_masked", 1'b0, irq);
        wr(IDX_INT_ENABLE, 8'h01);
        wr(IDX_STATUS, 8'h01);
        rdc("flag_w1", IDX_STATUS, 8'h01, 8'h00);
        chb("irq_clr", 1'b0, irq);
        $display("test clear done");
        ce <= 1'b0;
        p0 <= 8'h10;
        settle();
        chb("ce_hold", 1'b1, event_out);
        ce <= 1'b1;
        settle();
        chb("ce_run", 1'b0, event_out);
        wr(IDX_STATUS, 8'h01);
        $display("test clock enable done");
        p0 <= 8'h10;
        sleep <= SLEEP_STANDBY;
        settle();
        chb("stby_halt", 1'b0, cmp_en);
        wr(IDX_CONTROL, 8'hC1);
        settle();
        p0 <= 8'h64;
        settle();
        chb("stby_event", 1'b1, event_out);
        chb("stby_pad", 1'b1, pad_out);
        chb("stby_irq", 1'b0, irq);
        rdc("stby_flag", IDX_STATUS, 8'h01, 8'h00);
        clk_req <= 1'b1;
        p0 <= 8'h10;
        settle();
        rdc("stby_clk", IDX_STATUS, 8'h11, 8'h01);
        chb("stby_irq_clk", 1'b1, irq);
        sleep <= SLEEP_POWERDOWN;
        settle();
        chk("pdown", {6'h0, cmp_en, pad_oe}, 8'h00);
        chb("hresp", HRESP_OKAY, hresp);
        $display("test sleep done");
        end_of_test();
    end
endmodule : acmpc_top_tb
`default_nettype wire
